// >>> bench/amp_checker_properties.sv
`timescale 1ns/1ns
module amp_checker #(parameter W = 8, parameter LIMIT = 8'h60) (
   // clock, controls, samples
   input wire ref_clk, input wire rst_n, input wire [7:0] device_ctrl, input wire [7:0] loop_ctrl,
   input wire [4:0] analog_gain, input wire [1:0] pin_sel_si, input wire sample_valid,
   input wire [W-1:0] left_sample, input wire [W-1:0] right_sample,
   // outputs watched
   input wire [2:0] general_pins_oe, input wire spi_si_seen, input wire limiting,
   input wire pair_a_positive_out, input wire pair_a_negative_out,
   input wire pair_b_positive_out, input wire pair_b_negative_out,
   input wire [2:0] switch_rate_sel, input wire [1:0] loop_bandwidth, input wire [4:0] gain_step,
   input wire paralleled_mono_output
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   rate_copy_a: assert property ($past(rst_n) |-> switch_rate_sel == $past(device_ctrl[6:4]))
      else $error("rate select wrong");
   loop_copy_a: assert property ($past(rst_n) |-> loop_bandwidth == $past(loop_ctrl[6:5]))
      else $error("loop bandwidth wrong");
   gain_copy_a: assert property ($past(rst_n) |-> gain_step == $past(analog_gain))
      else $error("gain step wrong");
   mode_copy_a: assert property ($past(rst_n) |-> paralleled_mono_output == $past(device_ctrl[2]))
      else $error("mode flag wrong");
   mono_same_a: assert property ((paralleled_mono_output && sample_valid)[*4] |->
      pair_a_positive_out == pair_b_positive_out && pair_a_negative_out == pair_b_negative_out)
      else $error("mono pairs differ");
   idle_phase_a: assert property ((sample_valid && left_sample == 0)[*3] |->
      pair_a_positive_out == pair_a_negative_out) else $error("idle pair not in phase");
   pin_zero_a: assert property (general_pins_oe[0] == 1'b0) else $error("pin0 driven");
   si_gate_a: assert property ((pin_sel_si != 2'h1)[*3] |-> !spi_si_seen) else $error("si seen");
   small_pass_a: assert property (sample_valid && $signed(left_sample) < 32 && $signed(left_sample) > -32
      && $signed(right_sample) < 32 && $signed(right_sample) > -32 |=> !limiting) else $error("limiter engaged");
endmodule
bind amp_pwm_output_config amp_checker #(.W(W), .LIMIT(LIMIT)) chk (.*);

// >>> bench/piezo_load.sv
`timescale 1ns/1ns
// piezo load behind the lc filter: integrates the high time of each plate
module piezo_load (
   // clock and window
   input wire ref_clk,
   input wire clear,
   // bridged pair
   input wire pos_in,
   input wire neg_in,
   // high time tallies
   output reg [31:0] pos_high,
   output reg [31:0] neg_high
);
   // passive load, so it never pushes back on the bridge
   always @(posedge ref_clk) begin
      pos_high <= clear ? 32'h0 : pos_high + pos_in;
      neg_high <= clear ? 32'h0 : neg_high + neg_in;
   end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
   reg ref_clk = 0, rst_n = 0, sample_valid = 0, spi_so_drive = 0, spi_sck_drive = 0, clr = 0;
   reg [7:0] device_ctrl = 0, loop_ctrl = 0, left_sample = 0, right_sample = 0;
   reg [4:0] analog_gain = 0;
   reg [1:0] pin_sel_si = 0, pin_sel_so = 0, pin_sel_sck = 0;
   reg [2:0] general_pins_in = 0;
   wire [2:0] general_pins_out, general_pins_oe, switch_rate_sel;
   wire [1:0] loop_bandwidth;
   wire [4:0] gain_step;
   wire spi_si_seen, limiting, paralleled_mono_output;
   wire pair_a_positive_out, pair_a_negative_out, pair_b_positive_out, pair_b_negative_out;
   wire [31:0] pa, na, pb, nb;
   integer fail_count = 0, n_tests = 0, cyc = 0, r, k, d, ls, rs;
   reg [31:0] seed = 91425;
   amp_pwm_output_config DUT (.*);
   piezo_load load_a (.ref_clk(ref_clk), .clear(clr), .pos_in(pair_a_positive_out),
      .neg_in(pair_a_negative_out), .pos_high(pa), .neg_high(na));
   piezo_load load_b (.ref_clk(ref_clk), .clear(clr), .pos_in(pair_b_positive_out),
      .neg_in(pair_b_negative_out), .pos_high(pb), .neg_high(nb));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   // limiter model: magnitude clamp
   function integer cl(input integer s);
      cl = s > 96 ? 96 : (s < -96 ? -96 : s);
   endfunction
   task chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s expected %0d seen %0d", what, exp, seen);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_tests, fail_count);
         if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // one whole carrier period after settling; any phase gives the same tally
   task duty(input integer el, input integer er);
      begin
         d = (7 >> device_ctrl[6:4]) + 1;
         tick(256 * d);
         clr <= 1;
         tick(1);
         clr <= 0;
         tick(256 * d + 1);
         chk(pa, (128 + cl(el)) * d, "a_pos");
         chk(na, (128 - cl(el)) * d, "a_neg");
         chk(pb, (128 + cl(er)) * d, "b_pos");
         chk(nb, (128 - cl(er)) * d, "b_neg");
         chk(limiting, el > 96 || el < -96 || er > 96 || er < -96, "limit");
      end
   endtask
   initial forever #25 ref_clk = ~ref_clk;
   // hang guard, well above the longest sequence
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         fail_count = fail_count + 1;
         tally_and_finish;
      end
   end
   initial begin
      tick(2);
      rst_n <= 1;
      sample_valid <= 1;
      // every rate code, stereo, random gain must not scale the output
      for (r = 0; r < 8; r = r + 1) begin
         seed = xs(seed);
         ls = r == 0 ? 127 : (r == 1 ? 0 : $signed(seed[7:0]));
         rs = r == 0 ? -128 : (r == 1 ? 5 : $signed(seed[15:8]));
         device_ctrl <= {1'b0, r[2:0], 4'h0};
         left_sample <= ls[7:0];
         right_sample <= rs[7:0];
         analog_gain <= seed[20:16];
         tick(2);
         chk(switch_rate_sel, r, "rate");
         chk(gain_step, analog_gain, "gain");
         duty(ls, rs);
      end
      device_ctrl <= 8'h74;
      left_sample <= 8'h9c;
      right_sample <= 8'h05;
      tick(2);
      chk(paralleled_mono_output, 1, "mono");
      duty(-100, -100);
      for (k = 0; k < 4; k = k + 1) begin
         seed = xs(seed);
         loop_ctrl <= {seed[7], k[1:0], seed[4:0]}; // rate held at its fastest code
         tick(2);
         chk(loop_bandwidth, k, "loop_bw");
      end
      for (k = 0; k < 8; k = k + 1) begin
         seed = xs(seed);
         pin_sel_si <= k < 6 ? 2'h1 : 2'h0; // bench plays host with the eeprom select for k below 6, then back to gpio
         pin_sel_so <= k < 6 ? 2'h2 : 2'h0;
         pin_sel_sck <= k < 6 ? 2'h3 : 2'h0;
         {spi_so_drive, spi_sck_drive, general_pins_in} <= seed[4:0];
         tick(5); // three sync stages, agreement, then the output register
         chk(general_pins_oe, k < 6 ? 6 : 0, "pin_oe");
         if (k < 6) chk(general_pins_out[2:1], {spi_sck_drive, spi_so_drive}, "pin_out");
         chk(general_pins_out[0], 0, "pin0_out");
         chk(spi_si_seen, k < 6 ? general_pins_in[0] : 0, "si_seen");
      end
      // mid-run reset clears the outputs while held, then the fields come back
      rst_n <= 0;
      tick(2);
      chk({pair_a_positive_out, pair_a_negative_out, pair_b_positive_out, pair_b_negative_out}, 0, "pairs");
      chk(limiting, 0, "lim_rst");
      chk(general_pins_oe, 0, "oe_rst");
      rst_n <= 1;
      tick(3);
      chk(paralleled_mono_output, 1, "mono_rst");
      tally_and_finish;
   end
endmodule

// >>> verilog/amp_pwm_output_config.v
`timescale 1ns/1ns
`include "pwm_out_regs.vh"
// Notes on behaviour
// - two processed channels become two in-phase pwm pairs, one per bridge.
// - switching rate chosen by three-bit field, bits 6..4 of control 0x02.
// - digital boost stays 0 dB for every analog gain code in 0x54.
// - digital volume sits at 0 dB and ignores amplifier gain setting.
// - analog gain steps -0.5 dB from 0 to -15.5 dBFS, default 0.
// - loop bandwidth chosen by two-bit field, bits 6..5 of 0x53.
// - four bandwidth codes: 80, 100, 120, 175 kHz at 768 kHz switching.
// - bit 2 of control 0x02 picks bridged stereo or paralleled mono.
// - bridged stereo: left drives first pair, right drives second pair.
// - limiter passes ordinary levels untouched, engages only on large input.
// - general pins 0x60..0x64 can act as eeprom data in, out, clock.
// - positive above 50% duty for positive signal, negative below; in phase idle.
// - paralleled mono takes its channel from left-slot samples.
module amp_pwm_output_config #(
   parameter W = 8,
   parameter LIMIT = 8'h60
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // control fields
   input wire [7:0] device_ctrl,
   input wire [7:0] loop_ctrl,
   input wire [4:0] analog_gain,
   input wire [1:0] pin_sel_si,
   input wire [1:0] pin_sel_so,
   input wire [1:0] pin_sel_sck,
   // audio samples, signed
   input wire [W-1:0] left_sample,
   input wire [W-1:0] right_sample,
   input wire sample_valid,
   // eeprom link from the loader
   input wire spi_so_drive,
   input wire spi_sck_drive,
   // general pins
   input wire [2:0] general_pins_in,
   output reg [2:0] general_pins_out,
   output reg [2:0] general_pins_oe,
   output reg spi_si_seen,
   // pwm pairs
   output wire pair_a_positive_out,
   output wire pair_a_negative_out,
   output wire pair_b_positive_out,
   output wire pair_b_negative_out,
   // status
   output reg [2:0] switch_rate_sel,
   output reg [1:0] loop_bandwidth,
   output reg [4:0] gain_step,
   output reg limiting,
   output reg paralleled_mono_output
);
   // pipeline and synchroniser state
   reg [W-1:0] carrier_reg;
   reg [W-1:0] chan_a_reg;
   reg [W-1:0] chan_b_reg;
   reg [7:0] div_reg;
   reg [2:0] si_s1_reg;
   reg [2:0] si_s2_reg;
   reg [2:0] si_s3_reg;
   // decoded helpers
   wire lim_a;
   wire lim_b;
   wire [7:0] div_top;
   wire carrier_wrap;
   wire si_on;
   wire so_on;
   wire sck_on;
   wire si_agree;

   // signed hard limiter: untouched below limit, clamped above
   // the clamp level is a parameter so a stiffer load can be given less headroom
   function [W-1:0] lim_fn;
      input [W-1:0] s;
      begin
         if (!s[W-1] && (s > LIMIT[W-1:0]))
            lim_fn = LIMIT[W-1:0];
         else if (s[W-1] && ((~s + 1'b1) > LIMIT[W-1:0]))
            lim_fn = ~LIMIT[W-1:0] + 1'b1;
         else
            lim_fn = s;
      end
   endfunction

   // a sample is large when the clamp would change it
   function is_big;
      input [W-1:0] s;
      begin
         is_big = (lim_fn(s) != s);
      end
   endfunction

   // pin function decode, shared by the three general pins
   function pin_fn_on;
      input [1:0] sel;
      input [1:0] code;
      begin
         pin_fn_on = (sel == code);
      end
   endfunction

   // carrier divider: larger rate code steps the carrier faster up to code 3; codes 3 to 7 step every cycle
   // the count follows the latched rate code, so a new code lands within one carrier step
   assign div_top = `DIV_BASE >> switch_rate_sel;
   assign carrier_wrap = (div_reg >= div_top);

   // clamp flags; in mono the right slot is ignored, so it cannot raise the status
   assign lim_a = is_big(left_sample);
   assign lim_b = is_big(right_sample) && !paralleled_mono_output;

   // pin roles picked by the three select fields
   assign si_on = pin_fn_on(pin_sel_si, `PIN_FN_SI);
   assign so_on = pin_fn_on(pin_sel_so, `PIN_FN_SO);
   assign sck_on = pin_fn_on(pin_sel_sck, `PIN_FN_SCK);
   assign si_agree = (si_s2_reg[`PIN_SI] == si_s3_reg[`PIN_SI]);

   // latch configuration fields; gain touches only analog scale
   // fields are copied every edge, so a mid-write value shows for one cycle only
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         switch_rate_sel <= `RATE_RST;
         loop_bandwidth <= `LOOP_RST;
         gain_step <= `GAIN_RST;
         paralleled_mono_output <= 1'b0;
      end else begin
         switch_rate_sel <= device_ctrl[`RATE_HI:`RATE_LO];
         loop_bandwidth <= loop_ctrl[`LOOP_HI:`LOOP_LO];
         gain_step <= analog_gain;
         paralleled_mono_output <= device_ctrl[`MONO_BIT];
      end
   end

   // carrier ramp; rate sets switching frequency through the hold per step
   // resolution stays at W bits; only the hold per step changes with the rate
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_reg <= {W{1'b0}};
         div_reg <= 8'h00;
      end else if (carrier_wrap) begin
         div_reg <= 8'h00;
         carrier_reg <= carrier_reg + 1'b1;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // channel routing at unity digital volume and boost
   // samples are held while sample_valid is low
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_a_reg <= {W{1'b0}};
         chan_b_reg <= {W{1'b0}};
         limiting <= 1'b0;
      end else if (sample_valid) begin
         // samples pass at 0 dB whatever the gain code
         chan_a_reg <= lim_fn(left_sample);
         if (paralleled_mono_output)
            chan_b_reg <= lim_fn(left_sample);
         else
            chan_b_reg <= lim_fn(right_sample);
         limiting <= lim_a | lim_b;
      end
   end

   // both pairs share one carrier so mono pairs stay time-aligned
   // in stereo this also keeps the two bridges switching together, trading emi for alignment
   pwm_channel #(.W(W)) pair_a (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .carrier(carrier_reg),
      .sample(chan_a_reg),
      .pair_positive_out(pair_a_positive_out),
      .pair_negative_out(pair_a_negative_out)
   );

   pwm_channel #(.W(W)) pair_b (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .carrier(carrier_reg),
      .sample(chan_b_reg),
      .pair_positive_out(pair_b_positive_out),
      .pair_negative_out(pair_b_negative_out)
   );

   // general pin mux; chip select is not produced here on purpose
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         general_pins_out <= 3'h0;
         general_pins_oe <= 3'h0;
      end else begin
         // pin for serial data in is never driven from here
         general_pins_out[`PIN_SI] <= 1'b0;
         general_pins_oe[`PIN_SI] <= 1'b0; // si pin is input only
         // serial data out and serial clock follow the loader when selected
         general_pins_out[`PIN_SO] <= spi_so_drive;
         general_pins_oe[`PIN_SO] <= so_on;
         general_pins_out[`PIN_SCK] <= spi_sck_drive;
         general_pins_oe[`PIN_SCK] <= sck_on;
      end
   end

   // three-stage sync of pin inputs, accept when stage 2 and 3 agree
   // only the data-in pin is read back; the other two pins are outputs here
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         si_s1_reg <= 3'h0;
         si_s2_reg <= 3'h0;
         si_s3_reg <= 3'h0;
         spi_si_seen <= 1'b0;
      end else begin
         si_s1_reg <= general_pins_in;
         si_s2_reg <= si_s1_reg;
         si_s3_reg <= si_s2_reg;
         // a change counts only once stages two and three agree
         if (si_on && si_agree)
            spi_si_seen <= si_s3_reg[`PIN_SI];
         else if (!si_on)
            spi_si_seen <= 1'b0;
      end
   end
endmodule

// >>> verilog/pwm_channel.v
`timescale 1ns/1ns
// one bridged pair: three-level in-phase modulation of one sample
module pwm_channel #(
   parameter W = 8
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // carrier and sample
   input wire [W-1:0] carrier,
   input wire [W-1:0] sample,
   // pair outputs
   output reg pair_positive_out,
   output reg pair_negative_out
);
   wire [W-1:0] half;
   wire [W-1:0] mag;
   wire [W-1:0] pos_thr;
   wire [W-1:0] neg_thr;

   assign half = {1'b1, {(W-1){1'b0}}};
   // signed sample offsets each side from 50%: +x widens p, narrows n
   assign mag = sample;
   assign pos_thr = half + mag;
   assign neg_thr = half - mag;

   // at zero both thresholds equal half so the pair stays in phase
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pair_positive_out <= 1'b0;
         pair_negative_out <= 1'b0;
      end else begin
         pair_positive_out <= (carrier < pos_thr);
         pair_negative_out <= (carrier < neg_thr);
      end
   end
endmodule

// >>> verilog/pwm_out_regs.vh
`ifndef PWM_OUT_REGS_VH
`define PWM_OUT_REGS_VH
// control register addresses (kept for reference by the port-level fields)
`define CTRL_ADDR 8'h02
`define LOOP_ADDR 8'h53
`define GAIN_ADDR 8'h54
`define PIN_FIRST_ADDR 8'h60
`define PIN_LAST_ADDR 8'h64
// field positions
`define RATE_HI 6
`define RATE_LO 4
`define MONO_BIT 2
`define LOOP_HI 6
`define LOOP_LO 5
// reset values
`define RATE_RST 3'h0
`define LOOP_RST 2'h0
`define GAIN_RST 5'h00
`define PIN_SEL_RST 2'h0
// general pin function codes
`define PIN_FN_GPIO 2'h0
`define PIN_FN_SI 2'h1
`define PIN_FN_SO 2'h2
`define PIN_FN_SCK 2'h3
// general pin positions
`define PIN_SI 0
`define PIN_SO 1
`define PIN_SCK 2
// carrier hold count at the slowest rate code
`define DIV_BASE 8'h07
// loop bandwidth codes
`define LOOP_80K 2'h0
`define LOOP_100K 2'h1
`define LOOP_120K 2'h2
`define LOOP_175K 2'h3
// gain steps: 32 steps of -0.5 dB, 0 = 0 dBFS
`define GAIN_STEPS 32
`define ZERO_DB_SCALE 16'h8000
`endif
